// ---- hw/tcc_pin_sync.sv ----
`timescale 1ns/1ps
module tcc_pin_sync (
    input  wire logic clock,
    input  wire logic srst,
    input  wire logic pin,
    output logic      rise,
    output logic      fall
);
    logic s1_r;
    logic s2_r;
    logic s3_r;
    logic lvl_r;
    logic rise_r;
    logic fall_r;

    always_ff @(posedge clock)
    begin
        s1_r <= pin;
        s2_r <= s1_r;
        s3_r <= s2_r;
    end

    // Change is accepted only once two stages agree
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            lvl_r  <= 1'b0;
            rise_r <= 1'b0;
            fall_r <= 1'b0;
        end
        else
        begin
            rise_r <= (s2_r == s3_r) && (s3_r != lvl_r) && s3_r;
            fall_r <= (s2_r == s3_r) && (s3_r != lvl_r) && !s3_r;
            if (s2_r == s3_r)
            begin
                lvl_r <= s3_r;
            end
        end
    end

    assign rise = rise_r;
    assign fall = fall_r;
endmodule

// ---- hw/tcc_pkg.sv ----
// Function
// - Sixteen-bit up-counter, free-running or modulo, is the common time base.
// - Modulo register pair sets the counter's terminal count.
// - Reading the counter never disturbs counting.
// - Each channel is independently input capture or output compare, except channel 1 while linked.
// - Three-bit prescale select picks one of seven bus-clock derived counter rates.
// - Capture copies the counter into the channel value on the selected edge.
// - Capture updates the value whether or not the channel flag is set.
// - Capture or compare sets the channel flag; interrupt only when enabled.
// - Captured count appears five bus cycles after the qualifying edge.
// - Reset leaves the channel value registers unchanged.
// - Counter equal to compare value sets, clears or toggles the pin.
// - Channel 0 buffer mode links both channels onto pin 0; channel 0 first.
// - In linked mode each overflow hands control to the last written channel.
// - Linked: channel 0 control governs, channel 1 control unused, pin 1 released.
// - Toggle-on-wrap toggles the pin when the counter reaches the modulo value.
// - Pulse width is overflow to compare; clear for high, set for low pulse.
// - Counter runs zero through modulo inclusive; modulo 255 gives 256 ticks.
// - Overflow flag sets on reaching modulo; interrupt only when enabled.
// - Without toggle-on-wrap, overflow leaves the pin alone.
// - Mode 01 compare, 1x buffered; edge select 10 clears, 11 sets.
// - Buffer mode bit takes precedence over the single mode bit.
package tcc_pkg;

    localparam int TCC_CNT_W = 16;
    localparam int TCC_DIV_W = 6;

    // -----------------------------------------------------------------
    // Register byte offsets
    // -----------------------------------------------------------------
    localparam logic [4:0] TCC_REG_CTRL    = 5'h00;
    localparam logic [4:0] TCC_REG_COUNT   = 5'h04;
    localparam logic [4:0] TCC_REG_MODULO  = 5'h08;
    localparam logic [4:0] TCC_REG_CH0_SC  = 5'h0C;
    localparam logic [4:0] TCC_REG_CH0_VAL = 5'h10;
    localparam logic [4:0] TCC_REG_CH1_SC  = 5'h14;
    localparam logic [4:0] TCC_REG_CH1_VAL = 5'h18;

    // -----------------------------------------------------------------
    // Field positions
    // -----------------------------------------------------------------
    localparam int TCC_CTL_PS   = 0;
    localparam int TCC_CTL_STOP = 4;
    localparam int TCC_CTL_CLR  = 5;
    localparam int TCC_CTL_OVIE = 6;
    localparam int TCC_CTL_OVF  = 7;
    localparam int TCC_SC_TOV   = 0;
    localparam int TCC_SC_ELS   = 2;
    localparam int TCC_SC_MODE  = 4;
    localparam int TCC_SC_IE    = 6;
    localparam int TCC_SC_FLAG  = 7;

    // -----------------------------------------------------------------
    // Reset values and limits
    // -----------------------------------------------------------------
    localparam logic [15:0] TCC_MOD_RST  = 16'hFFFF;
    localparam logic [2:0]  TCC_PS_RST   = 3'h0;
    localparam logic [2:0]  TCC_PS_MAX   = 3'h6;
    localparam logic        TCC_STOP_RST = 1'b1;

    typedef enum logic [1:0] {
        TCC_MODE_CAP  = 2'b00,
        TCC_MODE_CMP  = 2'b01,
        TCC_MODE_BUF  = 2'b10,
        TCC_MODE_BUF2 = 2'b11
    } tcc_mode_t;

    // Capture reads bit 0 as rising, bit 1 as falling
    typedef enum logic [1:0] {
        TCC_ELS_OFF = 2'b00,
        TCC_ELS_TOG = 2'b01,
        TCC_ELS_CLR = 2'b10,
        TCC_ELS_SET = 2'b11
    } tcc_els_t;

    typedef struct packed {
        logic      ie;
        tcc_mode_t mode;
        tcc_els_t  els;
        logic      tov;
    } tcc_chan_ctl_t;

    localparam tcc_chan_ctl_t TCC_CHAN_RST = '{1'b0, TCC_MODE_CAP, TCC_ELS_OFF, 1'b0};

endpackage

// ---- hw/tcc_prescale.sv ----
`timescale 1ns/1ps
module tcc_prescale #(
    parameter int DIV_W = tcc_pkg::TCC_DIV_W
) (
    input  wire logic       clock,
    input  wire logic       srst,
    input  wire logic       clear,
    input  wire logic       run,
    input  wire logic [2:0] sel,
    output logic            tick
);
    logic [2:0]       sel_c;
    logic [DIV_W-1:0] mask;
    logic [DIV_W-1:0] div_r;
    logic             tick_r;

    // Select 7 has no rate of its own and repeats the slowest
    always_comb
    begin
        sel_c = (sel > tcc_pkg::TCC_PS_MAX) ? tcc_pkg::TCC_PS_MAX : sel;
        mask  = DIV_W'((1 << sel_c) - 1);
    end

    always_ff @(posedge clock)
    begin
        if (srst || clear)
        begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end
        else
        begin
            tick_r <= run && ((div_r & mask) == mask);
            if (run)
            begin
                div_r <= div_r + 1'b1;
            end
        end
    end

    assign tick = tick_r;
endmodule

// ---- hw/tcc_timer.sv ----
`timescale 1ns/1ps
module tcc_timer (
    input  wire logic        clock,
    input  wire logic        srst,
    input  wire logic [4:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic [31:0]      avs_readdata,
    output logic             avs_waitrequest,
    input  wire logic        chan0_pin_in,
    output logic             chan0_pin_out,
    output logic             chan0_pin_oe_n,
    input  wire logic        chan1_pin_in,
    output logic             chan1_pin_out,
    output logic             chan1_pin_oe_n,
    output logic             ovf_irq,
    output logic             chan0_irq,
    output logic             chan1_irq
);
    // -----------------------------------------------------------------
    // State
    // -----------------------------------------------------------------
    logic [2:0]                  ps_r;
    logic                        stop_r;
    logic                        ovie_r;
    logic                        ovf_flag_r;
    logic [15:0]                 count_r;
    logic [15:0]                 modulo_r;
    tcc_pkg::tcc_chan_ctl_t      ch_ctl_r [2];
    logic [15:0]                 ch_val_r [2];
    logic [1:0]                  ch_flag_r;
    logic [1:0]                  pin_out_r;
    logic [1:0]                  pin_oe_n_r;
    logic [1:0]                  ch_irq_r;
    logic                        ovf_irq_r;
    logic                        active_r;
    logic                        last_wr_r;
    logic                        wait_r;
    logic [31:0]                 rdata_r;

    logic                        grant;
    logic                        wr_en;
    logic                        cnt_clr;
    logic                        tick;
    logic [15:0]                 cnt_nxt;
    logic                        reach;
    logic                        linked;
    logic [1:0]                  rise;
    logic [1:0]                  fall;
    logic [1:0]                  cmp_mode;
    logic [1:0]                  cap_ev;
    logic [1:0]                  cmp_hit;
    logic [1:0]                  wr_sc;
    logic [1:0]                  wr_val;
    logic [15:0]                 cmp_val [2];
    logic [31:0]                 rd_mux;

    function automatic logic [15:0] merge16(
        input logic [15:0] old,
        input logic [31:0] wd,
        input logic [3:0]  be
    );
        merge16 = {be[1] ? wd[15:8] : old[15:8], be[0] ? wd[7:0] : old[7:0]};
    endfunction

    // -----------------------------------------------------------------
    // Pin synchronisers and prescaler
    // -----------------------------------------------------------------
    tcc_pin_sync u_sync0 (
        .clock (clock),
        .srst  (srst),
        .pin   (chan0_pin_in),
        .rise  (rise[0]),
        .fall  (fall[0])
    );

    tcc_pin_sync u_sync1 (
        .clock (clock),
        .srst  (srst),
        .pin   (chan1_pin_in),
        .rise  (rise[1]),
        .fall  (fall[1])
    );

    tcc_prescale #(
        .DIV_W (tcc_pkg::TCC_DIV_W)
    ) u_pre (
        .clock (clock),
        .srst  (srst),
        .clear (cnt_clr),
        .run   (!stop_r),
        .sel   (ps_r),
        .tick  (tick)
    );

    // -----------------------------------------------------------------
    // Bus decode
    // -----------------------------------------------------------------
    always_comb
    begin
        grant   = (avs_read || avs_write) && wait_r;
        wr_en   = grant && avs_write;
        cnt_clr = wr_en && avs_address == tcc_pkg::TCC_REG_CTRL && avs_byteenable[0]
                  && avs_writedata[tcc_pkg::TCC_CTL_CLR];
        wr_sc[0]  = wr_en && avs_address == tcc_pkg::TCC_REG_CH0_SC && avs_byteenable[0];
        wr_sc[1]  = wr_en && avs_address == tcc_pkg::TCC_REG_CH1_SC && avs_byteenable[0];
        wr_val[0] = wr_en && avs_address == tcc_pkg::TCC_REG_CH0_VAL;
        wr_val[1] = wr_en && avs_address == tcc_pkg::TCC_REG_CH1_VAL;
    end

    // Counter read is a plain mux tap, no side effect
    always_comb
    begin
        rd_mux = '0;
        case (avs_address)
            tcc_pkg::TCC_REG_CTRL:
                rd_mux[7:0] = {ovf_flag_r, ovie_r, 1'b0, stop_r, 1'b0, ps_r};
            tcc_pkg::TCC_REG_COUNT:   rd_mux[15:0] = count_r;
            tcc_pkg::TCC_REG_MODULO:  rd_mux[15:0] = modulo_r;
            tcc_pkg::TCC_REG_CH0_SC:
                rd_mux[7:0] = {ch_flag_r[0], ch_ctl_r[0].ie, ch_ctl_r[0].mode,
                               ch_ctl_r[0].els, 1'b0, ch_ctl_r[0].tov};
            tcc_pkg::TCC_REG_CH0_VAL: rd_mux[15:0] = ch_val_r[0];
            tcc_pkg::TCC_REG_CH1_SC:
                rd_mux[7:0] = {ch_flag_r[1], ch_ctl_r[1].ie, ch_ctl_r[1].mode,
                               ch_ctl_r[1].els, 1'b0, ch_ctl_r[1].tov};
            tcc_pkg::TCC_REG_CH1_VAL: rd_mux[15:0] = ch_val_r[1];
            default:                  rd_mux = '0;
        endcase
    end

    // One wait cycle, then a one-cycle acknowledge
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wait_r  <= 1'b1;
            rdata_r <= '0;
        end
        else
        begin
            wait_r <= !grant;
            if (grant && avs_read)
            begin
                rdata_r <= rd_mux;
            end
        end
    end

    // -----------------------------------------------------------------
    // Control registers
    // -----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ps_r     <= tcc_pkg::TCC_PS_RST;
            stop_r   <= tcc_pkg::TCC_STOP_RST;
            ovie_r   <= 1'b0;
            modulo_r <= tcc_pkg::TCC_MOD_RST;
        end
        else
        begin
            if (wr_en && avs_address == tcc_pkg::TCC_REG_CTRL && avs_byteenable[0])
            begin
                ps_r   <= avs_writedata[tcc_pkg::TCC_CTL_PS +: 3];
                stop_r <= avs_writedata[tcc_pkg::TCC_CTL_STOP];
                ovie_r <= avs_writedata[tcc_pkg::TCC_CTL_OVIE];
            end
            if (wr_en && avs_address == tcc_pkg::TCC_REG_MODULO)
            begin
                modulo_r <= merge16(modulo_r, avs_writedata, avs_byteenable);
            end
        end
    end

    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (srst)
            begin
                ch_ctl_r[i] <= tcc_pkg::TCC_CHAN_RST;
            end
            else if (wr_sc[i])
            begin
                ch_ctl_r[i].ie   <= avs_writedata[tcc_pkg::TCC_SC_IE];
                ch_ctl_r[i].mode <= tcc_pkg::tcc_mode_t'(avs_writedata[tcc_pkg::TCC_SC_MODE +: 2]);
                ch_ctl_r[i].els  <= tcc_pkg::tcc_els_t'(avs_writedata[tcc_pkg::TCC_SC_ELS +: 2]);
                ch_ctl_r[i].tov  <= avs_writedata[tcc_pkg::TCC_SC_TOV];
            end
        end
    end

    // -----------------------------------------------------------------
    // Counter
    // -----------------------------------------------------------------
    always_comb
    begin
        cnt_nxt = (count_r == modulo_r) ? '0 : count_r + 16'h0001;
        reach   = tick && (cnt_nxt == modulo_r);
    end

    always_ff @(posedge clock)
    begin
        if (srst || cnt_clr)
        begin
            count_r <= '0;
        end
        else if (tick)
        begin
            count_r <= cnt_nxt;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ovf_flag_r <= 1'b0;
        end
        else if (reach)
        begin
            ovf_flag_r <= 1'b1;
        end
        else if (wr_en && avs_address == tcc_pkg::TCC_REG_CTRL && avs_byteenable[0]
                 && avs_writedata[tcc_pkg::TCC_CTL_OVF])
        begin
            ovf_flag_r <= 1'b0;
        end
    end

    // -----------------------------------------------------------------
    // Channel decode
    // -----------------------------------------------------------------
    always_comb
    begin
        linked     = ch_ctl_r[0].mode[1];
        cmp_val[0] = (linked && active_r) ? ch_val_r[1] : ch_val_r[0];
        cmp_val[1] = ch_val_r[1];
        for (int i = 0; i < 2; i++)
        begin
            cmp_mode[i] = (ch_ctl_r[i].mode != tcc_pkg::TCC_MODE_CAP) && !(i == 1 && linked);
            cap_ev[i]   = (ch_ctl_r[i].mode == tcc_pkg::TCC_MODE_CAP) && !(i == 1 && linked)
                          && ((ch_ctl_r[i].els[0] && rise[i]) || (ch_ctl_r[i].els[1] && fall[i]));
            cmp_hit[i]  = tick && cmp_mode[i] && (cnt_nxt == cmp_val[i]);
        end
    end

    // Value registers keep their content across reset
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (cap_ev[i])
            begin
                ch_val_r[i] <= count_r;
            end
            else if (wr_val[i])
            begin
                ch_val_r[i] <= merge16(ch_val_r[i], avs_writedata, avs_byteenable);
            end
        end
    end

    // Hardware set beats a same-cycle software clear
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (srst)
            begin
                ch_flag_r[i] <= 1'b0;
            end
            else if (cap_ev[i] || cmp_hit[i])
            begin
                ch_flag_r[i] <= 1'b1;
            end
            else if (wr_sc[i] && avs_writedata[tcc_pkg::TCC_SC_FLAG])
            begin
                ch_flag_r[i] <= 1'b0;
            end
        end
    end

    // -----------------------------------------------------------------
    // Buffered pair selection
    // -----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            last_wr_r <= 1'b0;
        end
        else if (wr_val[0])
        begin
            last_wr_r <= 1'b0;
        end
        else if (wr_val[1])
        begin
            last_wr_r <= 1'b1;
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst || !linked)
        begin
            active_r <= 1'b0;
        end
        else if (reach)
        begin
            active_r <= last_wr_r;
        end
    end

    // -----------------------------------------------------------------
    // Pin drivers
    // -----------------------------------------------------------------
    // Compare wins over a coinciding wrap toggle
    always_ff @(posedge clock)
    begin
        for (int i = 0; i < 2; i++)
        begin
            if (srst)
            begin
                pin_out_r[i]  <= 1'b0;
                pin_oe_n_r[i] <= 1'b1;
            end
            else
            begin
                pin_oe_n_r[i] <= !(cmp_mode[i] && ch_ctl_r[i].els != tcc_pkg::TCC_ELS_OFF);
                if (cmp_hit[i])
                begin
                    case (ch_ctl_r[i].els)
                        tcc_pkg::TCC_ELS_TOG: pin_out_r[i] <= !pin_out_r[i];
                        tcc_pkg::TCC_ELS_CLR: pin_out_r[i] <= 1'b0;
                        tcc_pkg::TCC_ELS_SET: pin_out_r[i] <= 1'b1;
                        default:              pin_out_r[i] <= pin_out_r[i];
                    endcase
                end
                else if (reach && cmp_mode[i] && ch_ctl_r[i].tov)
                begin
                    pin_out_r[i] <= !pin_out_r[i];
                end
            end
        end
    end

    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            ovf_irq_r <= 1'b0;
            ch_irq_r  <= '0;
        end
        else
        begin
            ovf_irq_r <= ovf_flag_r && ovie_r;
            for (int i = 0; i < 2; i++)
            begin
                ch_irq_r[i] <= ch_flag_r[i] && ch_ctl_r[i].ie;
            end
        end
    end

    assign avs_readdata    = rdata_r;
    assign avs_waitrequest = wait_r;
    assign chan0_pin_out   = pin_out_r[0];
    assign chan0_pin_oe_n  = pin_oe_n_r[0];
    assign chan1_pin_out   = pin_out_r[1];
    assign chan1_pin_oe_n  = pin_oe_n_r[1];
    assign ovf_irq         = ovf_irq_r;
    assign chan0_irq       = ch_irq_r[0];
    assign chan1_irq       = ch_irq_r[1];

    // -----------------------------------------------------------------
    // Assertions
    // -----------------------------------------------------------------
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence s_wrap_tick;
        tick && count_r == modulo_r && !cnt_clr;
    endsequence

    sequence s_cnt_read;
        grant && avs_read && avs_address == tcc_pkg::TCC_REG_COUNT && !tick && !cnt_clr;
    endsequence

    a_count_up: assert property (tick && count_r != modulo_r && !cnt_clr
        |=> count_r == $past(count_r) + 16'h0001) else $error("count step wrong");
    a_wrap_zero: assert property (s_wrap_tick |=> count_r == '0)
        else $error("no wrap to zero");
    a_read_still: assert property (s_cnt_read |=> $stable(count_r))
        else $error("count read moved counter");
    a_ovf_flag: assert property (reach |=> ovf_flag_r)
        else $error("overflow flag missed");
    a_cap_value: assert property (cap_ev[0] |=> ch_val_r[0] == $past(count_r))
        else $error("capture value wrong");
    a_cap_sticky: assert property (cap_ev[1] && ch_flag_r[1] |=> ch_val_r[1] == $past(count_r))
        else $error("capture skipped with flag set");
    a_irq_gate: assert property (!ch_ctl_r[0].ie ##1 !ch_ctl_r[0].ie |-> !ch_irq_r[0])
        else $error("channel irq while disabled");
    a_cmp_clear: assert property (cmp_hit[0] && ch_ctl_r[0].els == tcc_pkg::TCC_ELS_CLR
        |=> !pin_out_r[0]) else $error("clear on compare failed");
    a_tov_off: assert property (reach && !cmp_hit[0] && !ch_ctl_r[0].tov
        |=> $stable(pin_out_r[0])) else $error("pin toggled without wrap toggle");
    a_link_switch: assert property (reach && linked |=> active_r == $past(last_wr_r))
        else $error("buffer pair not switched");
    a_link_release: assert property (linked ##1 linked |-> pin_oe_n_r[1])
        else $error("pin 1 driven while linked");
endmodule

// ---- tb/tcc_pin_model.sv ----
`timescale 1ns/1ps
module tcc_pin_model (
    input  wire logic pin0_drv,
    input  wire logic pin1_drv,
    input  wire logic chan0_pin_out,
    input  wire logic chan0_pin_oe_n,
    input  wire logic chan1_pin_out,
    input  wire logic chan1_pin_oe_n,
    output logic      chan0_pin_in,
    output logic      chan1_pin_in
);
    // Outside source yields whenever the block drives the pin
    assign chan0_pin_in = chan0_pin_oe_n ? pin0_drv : chan0_pin_out;
    assign chan1_pin_in = chan1_pin_oe_n ? pin1_drv : chan1_pin_out;
endmodule

// ---- tb/tcc_tb_top.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin n_mismatch++; \
    $display("mismatch at %0t: got %h exp %h", $time, a, b); end end
module two_channel_capture_compare_timer_tb_top;
    logic        clock = 1'b0;
    logic        srst = 1'b1;
    logic [4:0]  avs_address = 5'h00;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [31:0] avs_readdata;
    logic        avs_waitrequest;
    logic        p0_in;
    logic        p1_in;
    logic        drv0 = 1'b0;
    logic [1:0]  pout;
    logic [1:0]  poe_n;
    logic        ovf_irq;
    logic        c0_irq;
    logic        c1_irq;
    logic [2:0]  s;
    logic [31:0] q;
    logic [31:0] v;
    logic [31:0] e;
    int          n_mismatch = 0;
    int          checks_done = 0;
    int          cyc = 0;
    int          w;
    int          t0;

    always #12.5 clock = ~clock;
    always @(posedge clock) cyc <= cyc + 1;
    assign s = {pout, ovf_irq};

    tcc_timer dut_u (.clock(clock), .srst(srst), .avs_address(avs_address),
        .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(4'hF), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .chan0_pin_in(p0_in), .chan0_pin_out(pout[0]),
        .chan0_pin_oe_n(poe_n[0]), .chan1_pin_in(p1_in), .chan1_pin_out(pout[1]),
        .chan1_pin_oe_n(poe_n[1]), .ovf_irq(ovf_irq), .chan0_irq(c0_irq), .chan1_irq(c1_irq));

    tcc_pin_model pin_u (.pin0_drv(drv0), .pin1_drv(drv0), .chan0_pin_out(pout[0]),
        .chan0_pin_oe_n(poe_n[0]), .chan1_pin_out(pout[1]), .chan1_pin_oe_n(poe_n[1]),
        .chan0_pin_in(p0_in), .chan1_pin_in(p1_in));

    function automatic int pw(input int val);
        return val + 1;
    endfunction

    // Select values above the slowest rate repeat it
    function automatic int per(input int m, input int sel);
        return (m + 1) << ((sel > tcc_pkg::TCC_PS_MAX) ? tcc_pkg::TCC_PS_MAX : sel);
    endfunction

    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        @(posedge clock);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= ~wr;
        avs_writedata <= d;
        do @(posedge clock); while (avs_waitrequest !== 1'b0);
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    task automatic wait_for(input int i, input logic val);
        int n;
        n = 0;
        while (s[i] !== val && n < 5000)
        begin
            @(posedge clock);
            n++;
        end
        `CHK(n < 5000, 1'b1)
    endtask

    task automatic width(input int ch);
        wait_for(ch + 1, 1'b0);
        wait_for(ch + 1, 1'b1);
        w = 0;
        while (s[ch + 1] === 1'b1 && w < 5000)
        begin
            @(posedge clock);
            w++;
        end
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    initial
    begin
        repeat (60000) @(posedge clock);
        n_mismatch++;
        final_report;
    end

    initial
    begin
        void'($urandom(10744));
        repeat (8) @(posedge clock);
        srst <= 1'b0;
        bus(0, tcc_pkg::TCC_REG_CTRL, 0);
        `CHK(q[7:0], 8'h10)
        bus(0, tcc_pkg::TCC_REG_MODULO, 0);
        `CHK(q[15:0], tcc_pkg::TCC_MOD_RST)
        bus(0, 5'h1C, 0);
        `CHK(q, 32'h0)
        $display("test reset done");
        for (int i = 0; i < 6; i++)
        begin
            v = 15 + $urandom % 16;
            e = $urandom % 8;
            bus(1, tcc_pkg::TCC_REG_CTRL, 32'hB0);
            bus(1, tcc_pkg::TCC_REG_MODULO, v);
            bus(1, tcc_pkg::TCC_REG_CTRL, 32'h40 | e);
            wait_for(0, 1'b1);
            t0 = cyc;
            bus(1, tcc_pkg::TCC_REG_CTRL, 32'hC0 | e);
            bus(0, tcc_pkg::TCC_REG_COUNT, 0);
            `CHK(q[15:0] <= v[15:0], 1'b1)
            wait_for(0, 1'b0);
            wait_for(0, 1'b1);
            `CHK(cyc - t0, per(v, e))
        end
        $display("test period done");
        bus(1, tcc_pkg::TCC_REG_CTRL, 32'h30);
        for (int i = 0; i < 6; i++)
        begin
            e = (i == 0) ? 3 : 1 + $urandom % 3;
            bus(1, tcc_pkg::TCC_REG_CH0_SC, 32'h40 | (e << 2));
            bus(1, tcc_pkg::TCC_REG_CH1_SC, 32'h40 | (e << 2));
            bus(1, tcc_pkg::TCC_REG_CTRL, 32'h00);
            bus(1, tcc_pkg::TCC_REG_CTRL, 32'h10);
            bus(0, tcc_pkg::TCC_REG_COUNT, 0);
            t0 = q;
            drv0 <= ~drv0;
            repeat (8) @(posedge clock);
            if (drv0 ? e[0] : e[1])
                v = t0;
            bus(0, tcc_pkg::TCC_REG_CH0_VAL, 0);
            `CHK(q[15:0], v[15:0])
            bus(0, tcc_pkg::TCC_REG_CH1_VAL, 0);
            `CHK(q[15:0], v[15:0])
        end
        `CHK(c0_irq, 1'b1)
        srst <= 1'b1;
        repeat (3) @(posedge clock);
        srst <= 1'b0;
        bus(0, tcc_pkg::TCC_REG_CH0_VAL, 0);
        `CHK(q[15:0], v[15:0])
        $display("test capture done");
        bus(1, tcc_pkg::TCC_REG_MODULO, 40);
        bus(1, tcc_pkg::TCC_REG_CH1_VAL, 10);
        for (int k = 3; k > 0; k--)
        begin
            v = (k == 2) ? 0 : 1;
            bus(1, tcc_pkg::TCC_REG_CH1_SC, 32'h50 | (k << 2));
            bus(1, tcc_pkg::TCC_REG_CTRL, 32'h00);
            wait_for(2, v[0]);
            `CHK(poe_n[1], 1'b0)
            bus(1, tcc_pkg::TCC_REG_CTRL, 32'h30);
        end
        `CHK(c1_irq, 1'b1)
        $display("test compare done");
        bus(1, tcc_pkg::TCC_REG_MODULO, 99);
        bus(1, tcc_pkg::TCC_REG_CH1_VAL, 25);
        bus(1, tcc_pkg::TCC_REG_CH1_SC, 32'h19);
        bus(1, tcc_pkg::TCC_REG_CTRL, 32'h00);
        width(1);
        width(1);
        `CHK(w, pw(25))
        bus(1, tcc_pkg::TCC_REG_CH1_VAL, 15);
        width(1);
        `CHK(w, pw(15))
        `CHK(c1_irq, 1'b0)
        bus(1, tcc_pkg::TCC_REG_CH1_SC, 32'h18);
        repeat (120) @(posedge clock);
        w = 0;
        repeat (200) @(posedge clock) w += pout[1];
        `CHK(w, 0)
        $display("test pwm done");
        bus(1, tcc_pkg::TCC_REG_CTRL, 32'h30);
        bus(1, tcc_pkg::TCC_REG_CH0_VAL, 25);
        bus(1, tcc_pkg::TCC_REG_CH0_SC, 32'h29);
        bus(1, tcc_pkg::TCC_REG_CTRL, 32'h00);
        width(0);
        `CHK(w, pw(25))
        `CHK(poe_n[0], 1'b0)
        `CHK(poe_n[1], 1'b1)
        bus(1, tcc_pkg::TCC_REG_CH0_SC, 32'h39);
        bus(1, tcc_pkg::TCC_REG_CH1_VAL, 60);
        width(0);
        width(0);
        `CHK(w, pw(60))
        $display("test linked done");
        final_report;
    end
endmodule
